// ===== rtl/ccs_consts.vh
// Register offsets, field positions, reset values and timing counts
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH
// --------------------------------------------------------------
// Register byte addresses
// --------------------------------------------------------------
`define CCS_ADDR_FLAGS      8'h00
`define CCS_ADDR_ENABLES    8'h04
`define CCS_ADDR_CTRL       8'h08
`define CCS_ADDR_PRESCALER  8'h0c
`define CCS_ADDR_SEGMENTS   8'h10
`define CCS_ADDR_CORE_STAT  8'h14
// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define CCS_RST_FLAGS       8'h00
`define CCS_RST_ENABLES     8'h00
`define CCS_RST_CTRL        8'h00
`define CCS_RST_PRESCALER   8'h00
`define CCS_RST_SEGMENTS    8'h23
// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define CCS_F_RX3           7
`define CCS_F_RX2           6
`define CCS_F_RX1           5
`define CCS_F_TX            4
`define CCS_F_SC            3
`define CCS_F_OR            2
`define CCS_F_TE            1
`define CCS_F_ERROR_PENDING          0
`define CCS_E_EXTENDED_STATUS_CHANGE          6
`define CCS_E_RX_IRQ_ENABLE          5
`define CCS_E_TX_IRQ_ENABLE          4
`define CCS_E_STATUS_CHANGE_IRQ_ENABLE          3
`define CCS_E_OVERRUN_IRQ_ENABLE          2
`define CCS_E_TX_ERROR_IRQ_ENABLE          1
`define CCS_E_ETX           0
`define CCS_C_BUS_OFF_STATE          6
`define CCS_C_ERROR_PASSIVE_STATE          5
`define CCS_C_SELF_RECEPTION_ENABLE          4
`define CCS_C_NO_RETRANSMISSION          3
`define CCS_C_FAST_RESYNC          2
`define CCS_C_WAKEUP_PULSE          1
`define CCS_C_RUN           0
// --------------------------------------------------------------
// Resync counts and bit timing
// --------------------------------------------------------------
`define CCS_RECESSIVE_RUN   11
`define CCS_SLOW_SEQUENCES  128
`define CCS_SEG_OVERHEAD    3
`define CCS_TEC_BUSOFF      255
`define CCS_AXI_OKAY        2'b00
`define CCS_AXI_DECERR      2'b11
`endif

// ===== rtl/ccs_can_regs.v
// CAN controller general-purpose control and status register set
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
`include "ccs_consts.vh"

// Overview of operation
// - Receive flag n sets when an error-free message lands in buffer n.
// - Clearing the buffer ready bit also clears its receive flag.
// - Transmit flag sets on completion, or on arbitration won with early transmit.
// - Status flag sets on standby wake, entering passive or bus-off while running, or receive error with extended status enabled.
// - Overrun flag sets when an accepted message finds no free buffer.
// - Transmit-error flag sets on an error during queued transmission.
// - Error-pending bit reads high while status, overrun or tx-error flag is set.
// - Writing zero to a flag bit clears that flag.
// - Interrupt request rises only for events whose enable bit is set.
// - Extended status enable makes every receive error set the status flag.
// - Bus-off bit high while transmit error counter exceeds 255.
// - Error-passive bit high only while node is error passive.
// - Self-reception enable receives own frames; else own frames are discarded.
// - No-retransmission stops retries; otherwise retry until success.
// - Leaving standby waits 128 runs of 11 recessive bits, or 1 run if fast and not bus-off.
// - Wake-up pulse bit drives a dominant pulse when leaving standby.
// - Run bit reads 1 after clearing until standby is really reached.
// - Time quantum is clock period times prescaler plus one.
// - Resync jump limited to jump width plus one quanta.
// - Segment lengths are field plus one; bit time is both fields plus 3.
// - Prescaler and timing registers writable only in standby.
module ccs_can_regs #(
    parameter ADDR_W = 8
) (
    input  wire              clk_sys,
    input  wire              resetn,
    input  wire              clk_en,
    // AXI4-Lite slave
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Events from the protocol core, one-cycle pulses, then node state levels
    input  wire [2:0]        rx_stored,
    input  wire [2:0]        buf_ready_cleared,
    input  wire              tx_completed,
    input  wire              tx_arbitration_won,
    input  wire              tx_error,
    input  wire              rx_error,
    input  wire              overrun_event,
    input  wire              standby_dominant,
    input  wire              error_passive_in,
    input  wire              bus_off_in,
    input  wire              transfer_active,
    // Controls to the protocol core
    output reg               irq_request,
    output reg               run_active,
    output reg               standby_state,
    output reg               self_reception_enable,
    output reg               no_retransmission,
    output reg               fast_resync,
    output reg               wakeup_pulse_req,
    output reg  [8:0]        resync_bits_needed,
    output reg  [7:0]        resync_sequences,
    output reg  [6:0]        quantum_divide,
    output reg  [2:0]        jump_width_tq,
    output reg  [4:0]        segment_one_tq,
    output reg  [3:0]        segment_two_tq,
    output reg  [4:0]        bit_time_tq
);

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    reg  [7:1] flags_r;
    reg  [6:0] enables_r;
    reg  [4:0] ctrl_r;          // self_reception_enable no_retransmission fast_resync wakeup_pulse run request
    reg  [7:0] prescaler_r;
    reg  [6:0] segments_r;
    reg        bus_off_r;
    reg        err_passive_r;
    reg        aw_held_r;
    reg        w_held_r;
    reg  [ADDR_W-1:0] awaddr_r;
    reg  [7:0] wdata_r;
    reg        wstrb0_r;

    // Counts cut to the width of the port they drive
    localparam [31:0] RUN_BITS  = `CCS_RECESSIVE_RUN;
    localparam [31:0] SLOW_SEQS = `CCS_SLOW_SEQUENCES;
    localparam [31:0] SEG_OVH   = `CCS_SEG_OVERHEAD;

    wire       error_pending = flags_r[`CCS_F_SC] | flags_r[`CCS_F_OR]
                             | flags_r[`CCS_F_TE];
    wire       wr_go    = aw_held_r & w_held_r & ~s_axi_bvalid & wstrb0_r;
    wire       wr_flags = wr_go & (awaddr_r == `CCS_ADDR_FLAGS);

    // --------------------------------------------------------------
    // Flag set and clear
    // --------------------------------------------------------------
    reg  [7:1] set_v;
    reg  [7:1] clr_v;
    reg        sc_set;
    always @* begin
        sc_set = (standby_state & standby_dominant)
               | (run_active & ((error_passive_in & ~err_passive_r)
               | (bus_off_in & ~bus_off_r)))
               | (enables_r[`CCS_E_EXTENDED_STATUS_CHANGE] & rx_error);
        set_v = {rx_stored[2], rx_stored[1], rx_stored[0],
                 enables_r[`CCS_E_ETX] ? tx_arbitration_won
                                       : tx_completed,
                 sc_set,
                 overrun_event,
                 tx_error};
        clr_v = {buf_ready_cleared[2], buf_ready_cleared[1],
                 buf_ready_cleared[0], 4'h0};
        if (wr_flags) begin
            clr_v = clr_v | ~wdata_r[7:1];
        end
    end

    wire in_standby = ~ctrl_r[0] & ~transfer_active;
    wire [7:0] wd   = wdata_r;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flags_r       <= 7'h00;
            enables_r     <= 7'h00;
            ctrl_r        <= 5'h00;
            prescaler_r   <= `CCS_RST_PRESCALER;
            segments_r    <= 7'h23;
            bus_off_r     <= 1'b0;
            err_passive_r <= 1'b0;
        end else if (clk_en) begin
            flags_r       <= (flags_r & ~clr_v) | set_v;          // set wins
            bus_off_r     <= bus_off_in;
            err_passive_r <= error_passive_in;
            if (wr_go && awaddr_r == `CCS_ADDR_ENABLES) begin
                enables_r <= wd[6:0];
            end
            if (wr_go && awaddr_r == `CCS_ADDR_CTRL) begin
                ctrl_r <= {wd[4:1], wd[0]};
            end
            if (wr_go && awaddr_r == `CCS_ADDR_PRESCALER && standby_state) begin
                prescaler_r <= wd;
            end
            if (wr_go && awaddr_r == `CCS_ADDR_SEGMENTS && standby_state) begin
                segments_r <= wd[6:0];
            end
        end
    end

    // --------------------------------------------------------------
    // Core controls
    // --------------------------------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_request           <= 1'b0;
            run_active            <= 1'b0;
            standby_state         <= 1'b1;
            self_reception_enable <= 1'b0;
            no_retransmission     <= 1'b0;
            fast_resync           <= 1'b0;
            wakeup_pulse_req      <= 1'b0;
            resync_bits_needed    <= 9'd11;
            resync_sequences      <= 8'd128;
            quantum_divide        <= 7'd1;
            jump_width_tq         <= 3'd1;
            segment_one_tq        <= 5'd4;
            segment_two_tq        <= 4'd3;
            bit_time_tq           <= 5'd8;
        end else if (clk_en) begin
            irq_request <= (|flags_r[7:5] & enables_r[`CCS_E_RX_IRQ_ENABLE])
                         | (flags_r[`CCS_F_TX] & enables_r[`CCS_E_TX_IRQ_ENABLE])
                         | (flags_r[`CCS_F_SC] & enables_r[`CCS_E_STATUS_CHANGE_IRQ_ENABLE])
                         | (flags_r[`CCS_F_OR] & enables_r[`CCS_E_OVERRUN_IRQ_ENABLE])
                         | (flags_r[`CCS_F_TE] & enables_r[`CCS_E_TX_ERROR_IRQ_ENABLE]);
            // Standby only once the ongoing transfer is over
            if (ctrl_r[0]) begin
                run_active <= 1'b1;
            end else if (!transfer_active) begin
                run_active <= 1'b0;
            end
            standby_state         <= in_standby & ~ctrl_r[0];
            self_reception_enable <= ctrl_r[4];
            no_retransmission     <= ctrl_r[3];
            fast_resync           <= ctrl_r[2];
            wakeup_pulse_req      <= ctrl_r[1] & ctrl_r[0] & standby_state;
            resync_bits_needed    <= RUN_BITS[8:0];
            resync_sequences      <= (ctrl_r[2] & ~bus_off_in) ? 8'd1
                                   : SLOW_SEQS[7:0];
            quantum_divide        <= {1'b0, prescaler_r[5:0]} + 7'd1;
            jump_width_tq         <= {1'b0, prescaler_r[7:6]} + 3'd1;
            segment_one_tq        <= {1'b0, segments_r[3:0]} + 5'd1;
            segment_two_tq        <= {1'b0, segments_r[6:4]} + 4'd1;
            bit_time_tq           <= {1'b0, segments_r[3:0]}
                                   + {2'b00, segments_r[6:4]}
                                   + SEG_OVH[4:0];
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite write channel
    // --------------------------------------------------------------
    wire wr_hit = (awaddr_r == `CCS_ADDR_FLAGS) | (awaddr_r == `CCS_ADDR_ENABLES)
                | (awaddr_r == `CCS_ADDR_CTRL) | (awaddr_r == `CCS_ADDR_PRESCALER)
                | (awaddr_r == `CCS_ADDR_SEGMENTS)
                | (awaddr_r == `CCS_ADDR_CORE_STAT);

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= {ADDR_W{1'b0}};
            wdata_r       <= 8'h00;
            wstrb0_r      <= 1'b0;
        end else if (clk_en) begin
            s_axi_awready <= ~aw_held_r & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= ~w_held_r & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r     <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r     <= 1'b1;
                wdata_r      <= s_axi_wdata[7:0];
                wstrb0_r     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (aw_held_r && w_held_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `CCS_AXI_OKAY : `CCS_AXI_DECERR;
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                wstrb0_r     <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite read channel
    // --------------------------------------------------------------
    reg [7:0] rd_v;
    reg       rd_hit;
    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `CCS_ADDR_FLAGS:     rd_v = {flags_r, error_pending};
            `CCS_ADDR_ENABLES:   rd_v = {1'b0, enables_r};
            `CCS_ADDR_CTRL:      rd_v = {1'b0, bus_off_in,
                                         error_passive_in & ~bus_off_in,
                                         ctrl_r[4:1],
                                         ctrl_r[0] | run_active};
            `CCS_ADDR_PRESCALER: rd_v = prescaler_r;
            `CCS_ADDR_SEGMENTS:  rd_v = {1'b0, segments_r};
            `CCS_ADDR_CORE_STAT: rd_v = {6'h00, transfer_active, standby_state};
            default: begin
                rd_v   = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else if (clk_en) begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h00_0000, rd_v};
                s_axi_rresp   <= rd_hit ? `CCS_AXI_OKAY : `CCS_AXI_DECERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // ccs_can_regs

// ===== dv/ccs_can_regs_monitor.sv
// Concurrent checks on the register block ports
`timescale 1ns/100ps
module ccs_can_regs_monitor #(
    parameter ADDR_W = 8
) (
    input wire              clk_sys,
    input wire              resetn,
    input wire              clk_en,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire              s_axi_arvalid,
    input wire              s_axi_arready,
    input wire [31:0]       s_axi_rdata,
    input wire [1:0]        s_axi_rresp,
    input wire              s_axi_rvalid,
    input wire              s_axi_rready,
    input wire              s_axi_wvalid,
    input wire              s_axi_wready,
    input wire              s_axi_bvalid,
    input wire              s_axi_bready,
    input wire              transfer_active,
    input wire              standby_state,
    input wire              wakeup_pulse_req,
    input wire [8:0]        resync_bits_needed,
    input wire [6:0]        quantum_divide,
    input wire [4:0]        segment_one_tq,
    input wire [3:0]        segment_two_tq,
    input wire [4:0]        bit_time_tq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_bit_time_sum: assert property (bit_time_tq == segment_one_tq + segment_two_tq + 5'd1)
        else $error("bit time differs from segment sum");
    a_resync_run: assert property (resync_bits_needed == 9'd11)
        else $error("recessive run length wrong");
    a_timing_frozen: assert property (!standby_state [*4] |-> $stable(quantum_divide) && $stable(bit_time_tq))
        else $error("timing changed outside standby");
    a_drain_hold: assert property (clk_en && transfer_active |=> !standby_state)
        else $error("standby entered during transfer");
    a_wake_standby: assert property (wakeup_pulse_req |-> $past(standby_state) && !standby_state)
        else $error("wake pulse outside standby");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
        else $error("write answer missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
        |=> s_axi_rresp == 2'b11)
        else $error("unmapped read not refused");
endmodule // ccs_can_regs_monitor

bind ccs_can_regs ccs_can_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .clk_sys, .resetn, .clk_en, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .transfer_active, .standby_state,
    .wakeup_pulse_req, .resync_bits_needed, .quantum_divide, .segment_one_tq,
    .segment_two_tq, .bit_time_tq
);

// ===== dv/ccs_core_model.sv
// Behavioural protocol core feeding events and node state
`timescale 1ns/100ps
module ccs_core_model (
    input  wire       clk_sys,
    output wire [2:0] rx_stored,
    output wire [2:0] buf_ready_cleared,
    output wire       tx_completed,
    output wire       tx_arbitration_won,
    output wire       tx_error,
    output wire       rx_error,
    output wire       overrun_event,
    output wire       standby_dominant,
    output reg        error_passive_in,
    output wire       bus_off_in,
    output reg        transfer_active
);
    reg [11:0] ev_r = 12'h000;
    reg [8:0]  tec_r = 9'h000;
    initial error_passive_in = 1'b0;
    initial transfer_active = 1'b0;
    assign {standby_dominant, overrun_event, rx_error, tx_error, tx_arbitration_won,
            tx_completed, buf_ready_cleared, rx_stored} = ev_r;
    assign bus_off_in = (tec_r > 9'd255);
    // One-cycle event pulse
    task pulse(input [11:0] v);
        begin
            @(posedge clk_sys);
            ev_r <= v;
            @(posedge clk_sys);
            ev_r <= 12'h000;
        end
    endtask
    // Node state levels
    task levels(input p, input [8:0] tec, input act);
        begin
            @(posedge clk_sys);
            error_passive_in <= p;
            tec_r <= tec;
            transfer_active <= act;
        end
    endtask
endmodule // ccs_core_model

// ===== dv/ccs_can_regs_tb.sv
// Self-checking bench for the control and status register set
`timescale 1ns/100ps
module ccs_can_regs_tb;
    reg         clk_sys = 1'b0;
    reg         resetn = 1'b0;
    reg  [7:0]  awaddr = 8'h00;
    reg  [7:0]  araddr = 8'h00;
    reg  [31:0] wdata = 32'h0;
    reg         awvalid = 1'b0;
    reg         wvalid = 1'b0;
    reg         bready = 1'b0;
    reg         arvalid = 1'b0;
    reg         rready = 1'b0;
    reg         clk_en = 1'b1;
    reg  [3:0]  wstrb = 4'h1;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [2:0]  rx_stored, buf_ready_cleared, jump_width_tq;
    wire        tx_completed, tx_arbitration_won, tx_error, rx_error, overrun_event;
    wire        standby_dominant, error_passive_in, bus_off_in, transfer_active;
    wire        irq_request, run_active, standby_state, self_reception_enable;
    wire        no_retransmission, fast_resync, wakeup_pulse_req;
    wire [8:0]  resync_bits_needed;
    wire [7:0]  resync_sequences;
    wire [6:0]  quantum_divide;
    wire [4:0]  segment_one_tq, bit_time_tq;
    wire [3:0]  segment_two_tq;
    integer     num_errors = 0;
    integer     checks = 0;
    integer     i;
    always #2 clk_sys = ~clk_sys;

    ccs_can_regs uut (
        .clk_sys, .resetn, .clk_en, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_stored, .buf_ready_cleared, .tx_completed, .tx_arbitration_won, .tx_error,
        .rx_error, .overrun_event, .standby_dominant, .error_passive_in, .bus_off_in,
        .transfer_active, .irq_request, .run_active, .standby_state, .self_reception_enable,
        .no_retransmission, .fast_resync, .wakeup_pulse_req, .resync_bits_needed,
        .resync_sequences, .quantum_divide, .jump_width_tq, .segment_one_tq,
        .segment_two_tq, .bit_time_tq
    );
    ccs_core_model core (
        .clk_sys, .rx_stored, .buf_ready_cleared, .tx_completed, .tx_arbitration_won,
        .tx_error, .rx_error, .overrun_event, .standby_dominant, .error_passive_in,
        .bus_off_in, .transfer_active
    );
    // ------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------
    task chk(input [31:0] g, input [31:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        reg aw_p, w_p;
        begin
            @(posedge clk_sys);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            aw_p = 1'b1;
            w_p = 1'b1;
            while (aw_p || w_p) begin
                @(posedge clk_sys);
                if (aw_p && awready) begin
                    aw_p = 1'b0;
                    awvalid <= 1'b0;
                end
                if (w_p && wready) begin
                    w_p = 1'b0;
                    wvalid <= 1'b0;
                end
            end
            @(posedge clk_sys);
            while (!bvalid) @(posedge clk_sys);
            bready <= 1'b0;
            chk(bresp, 2'b00);
        end
    endtask
    task rd(input [7:0] a, input [7:0] e, input [1:0] er);
        begin
            @(posedge clk_sys);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            @(posedge clk_sys);
            while (!arready) @(posedge clk_sys);
            arvalid <= 1'b0;
            @(posedge clk_sys);
            while (!rvalid) @(posedge clk_sys);
            rready <= 1'b0;
            chk(rresp, er);
            if (er == 2'b00) chk(rdata, {24'h0, e});
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        begin
            rd(8'h00, 8'h00, 2'b00);
            rd(8'h04, 8'h00, 2'b00);
            rd(8'h08, 8'h00, 2'b00);
            rd(8'h0c, 8'h00, 2'b00);
            rd(8'h10, 8'h23, 2'b00);
            rd(8'h14, 8'h01, 2'b00);
            rd(8'h18, 8'h00, 2'b11);
        end
    endtask
    task t_flags;
        begin
            core.pulse(12'h547);
            rd(8'h00, 8'hf7, 2'b00);
            wr(8'h00, 8'hfb);
            rd(8'h00, 8'hf3, 2'b00);
            core.pulse(12'h020);
            rd(8'h00, 8'h73, 2'b00);
            wr(8'h00, 8'hfd);
            rd(8'h00, 8'h70, 2'b00);
            wr(8'h00, 8'h00);
            rd(8'h00, 8'h00, 2'b00);
        end
    endtask
    task t_events;
        begin
            wr(8'h04, 8'h01);
            core.pulse(12'h080);
            rd(8'h00, 8'h10, 2'b00);
            wr(8'h00, 8'h00);
            wr(8'h04, 8'h00);
            core.pulse(12'h280);
            rd(8'h00, 8'h00, 2'b00);
            wr(8'h04, 8'h40);
            core.pulse(12'h200);
            rd(8'h00, 8'h09, 2'b00);
            wr(8'h00, 8'h00);
            core.pulse(12'h800);
            rd(8'h00, 8'h09, 2'b00);
            wr(8'h00, 8'h00);
            wr(8'h04, 8'h00);
        end
    endtask
    task t_irq;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                core.pulse(60'h001_040_800_400_100 >> (i * 12));
                cyc(3);
                chk(irq_request, 1'b0);
                wr(8'h04, 8'h02 << i);
                cyc(2);
                chk(irq_request, 1'b1);
                wr(8'h00, 8'h00);
                cyc(2);
                chk(irq_request, 1'b0);
                wr(8'h04, 8'h00);
            end
        end
    endtask
    task t_timing;
        begin
            wr(8'h0c, 8'hc5);
            wr(8'h10, 8'h7f);
            cyc(2);
            chk(quantum_divide, 7'd6);
            chk(jump_width_tq, 3'd4);
            chk({segment_one_tq, segment_two_tq, bit_time_tq}, {5'd16, 4'd8, 5'd25});
            wr(8'h08, 8'h1f);
            cyc(1);
            chk(wakeup_pulse_req, 1'b1);
            cyc(2);
            chk({self_reception_enable, no_retransmission, fast_resync}, 3'h7);
            chk({resync_sequences, run_active, standby_state}, {8'd1, 2'b10});
            wr(8'h0c, 8'h01);
            wr(8'h10, 8'h00);
            rd(8'h0c, 8'hc5, 2'b00);
            rd(8'h10, 8'h7f, 2'b00);
        end
    endtask
    task t_status;
        begin
            core.levels(1'b1, 9'd0, 1'b0);
            cyc(2);
            rd(8'h08, 8'h3f, 2'b00);
            rd(8'h00, 8'h09, 2'b00);
            wr(8'h00, 8'h00);
            core.levels(1'b0, 9'd300, 1'b0);
            cyc(3);
            chk(resync_sequences, 8'd128);
            rd(8'h08, 8'h5f, 2'b00);
            rd(8'h00, 8'h09, 2'b00);
            wr(8'h00, 8'h00);
            core.levels(1'b0, 9'd0, 1'b1);
            wr(8'h08, 8'h00);
            rd(8'h08, 8'h01, 2'b00);
            chk(standby_state, 1'b0);
            core.levels(1'b0, 9'd0, 1'b0);
            cyc(3);
            rd(8'h08, 8'h00, 2'b00);
            chk(standby_state, 1'b1);
        end
    endtask
    task t_refuse;
        begin
            wstrb <= 4'h0;
            wr(8'h04, 8'h3f);
            wstrb <= 4'h1;
            rd(8'h04, 8'h00, 2'b00);
            clk_en <= 1'b0;
            core.pulse(12'h400);
            cyc(2);
            clk_en <= 1'b1;
            rd(8'h00, 8'h00, 2'b00);
        end
    endtask
    task conclude;
        begin
            $display("Checks %0d, errors %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        cyc(2);
        t_reset;
        t_flags;
        t_events;
        t_irq;
        t_timing;
        t_status;
        t_refuse;
        conclude;
    end
    initial begin
        #40000;
        num_errors = num_errors + 1;
        conclude;
    end
endmodule // ccs_can_regs_tb
